/* rtl/tcm_timers.sv */
// Purpose: four counter/timers with clock selection and prescaler
// Assumes: classic Wishbone slave, SUSPEND_IN from logic on CLK_IN
// Notes: in suspend only external-clock ticks of timer 3 go on
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`include "tcm_cfg.svh"
module tcm_timers import tcm_pkg::*; (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic TIM0_EVENT_PIN_IN,
    input wire logic TIM1_EVENT_PIN_IN,
    input wire logic EXT_OSC_IN,
    input wire logic SUSPEND_IN,
    output logic WAKE_OUT
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] tcm_merge(input logic [31:0] o,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b+:8] = d[8*b+:8];
            end
        end
        return r;
    endfunction

    // returns {high overflow, low overflow, next count}
    function automatic logic [17:0] tcm_t01_step(input tcm_mode_t m,
        input logic [15:0] c, input logic tl, input logic th);
        logic [15:0] n;
        logic [12:0] v;
        logic ol;
        logic oh;
        n = c;
        v = {c[15:8], c[4:0]};
        ol = 1'b0;
        oh = 1'b0;
        case (m)
            TCM_M13: if (tl) begin
                ol = (v == 13'h1FFF); // [R15]
                v = v + 13'h0001;
                n = {v[12:5], c[7:5], v[4:0]};
            end
            TCM_M16: if (tl) begin
                ol = (c == 16'hFFFF);
                n = c + 16'h0001;
            end
            TCM_M8AR: if (tl) begin
                ol = (c[7:0] == 8'hFF);
                n[7:0] = ol ? c[15:8] : c[7:0] + 8'h01;
            end
            TCM_MSPLIT: begin
                if (tl) begin
                    ol = (c[7:0] == 8'hFF);
                    n[7:0] = c[7:0] + 8'h01;
                end
                if (th) begin
                    oh = (c[15:8] == 8'hFF);
                    n[15:8] = c[15:8] + 8'h01;
                end
            end
            default: n = c;
        endcase
        return {oh, ol, n}; // [R2]
    endfunction

    function automatic logic [17:0] tcm_ar_step(input logic split,
        input logic [15:0] c, input logic [15:0] r, input logic tl,
        input logic th);
        logic [15:0] n;
        logic ol;
        logic oh;
        n = c;
        ol = 1'b0;
        oh = 1'b0;
        if (!split) begin
            if (tl) begin
                ol = (c == 16'hFFFF);
                n = ol ? r : c + 16'h0001;
            end
        end else begin
            if (tl) begin
                ol = (c[7:0] == 8'hFF);
                n[7:0] = ol ? r[7:0] : c[7:0] + 8'h01;
            end
            if (th) begin
                oh = (c[15:8] == 8'hFF);
                n[15:8] = oh ? r[15:8] : c[15:8] + 8'h01;
            end
        end
        return {oh, ol, n}; // [R3]
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic ack;
    logic [7:0] clk_sel;
    logic [7:0] t01_ctl;
    logic [5:0] t23_ctl;
    logic [6:0] ovf;
    logic [15:0] t01_cnt [2];
    logic [15:0] t23_cnt [2];
    logic [15:0] t23_rld [2];
    logic [3:0] div12;
    logic [5:0] div48;
    logic [2:0] ext8;
    logic [2:0] pin_fall;
    logic [2:0] pin_rise;
    logic [2:0] pins;

    wire logic req = WB_CYC_IN & WB_STB_IN & ~ack;
    wire logic wr = req & WB_WE_IN;
    wire logic [7:0] adr = {WB_ADR_IN[7:2], 2'b00};
    wire logic susp = SUSPEND_IN;
    wire logic sys_ok = ~susp;
    wire logic wr_ck = wr & (adr == `TCM_OFS_CKSEL);
    wire logic wr_t01 = wr & (adr == `TCM_OFS_T01CTL);
    wire logic wr_t23 = wr & (adr == `TCM_OFS_T23CTL);
    wire logic wr_fl = wr & (adr == `TCM_OFS_FLAGS);
    wire logic [1:0] wr_t01cnt = {wr & (adr == `TCM_OFS_T1CNT),
                                  wr & (adr == `TCM_OFS_T0CNT)};
    wire logic [1:0] wr_t23cnt = {wr & (adr == `TCM_OFS_T3CNT),
                                  wr & (adr == `TCM_OFS_T2CNT)};
    wire logic [1:0] wr_t23rld = {wr & (adr == `TCM_OFS_T3RLD),
                                  wr & (adr == `TCM_OFS_T2RLD)};

    ////////////////////////////////////////////////////////////////////////
    // event pins and external oscillator
    assign pins = {EXT_OSC_IN, TIM1_EVENT_PIN_IN, TIM0_EVENT_PIN_IN};
    generate
        for (genvar g = 0; g < 3; g++) begin : g_sync
            tcm_edge_sync u_sync (
                .clk_in(CLK_IN),
                .rstn_in(RSTN_IN),
                .pin_in(pins[g]),
                .fall_out(pin_fall[g]),
                .rise_out(pin_rise[g])
            );
        end
    endgenerate

    // system clock dividers stop with the system clock in suspend
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            div12 <= 4'h0;
            div48 <= 6'h00;
            ext8 <= 3'h0;
        end else begin
            if (sys_ok) begin
                div12 <= (div12 == `TCM_DIV12_LAST) ? 4'h0 : div12 + 4'h1;
                div48 <= (div48 == `TCM_DIV48_LAST) ? 6'h00 : div48 + 6'h01;
            end
            if (pin_rise[2]) begin
                ext8 <= ext8 + 3'h1;
            end
        end
    end

    wire logic tick12 = sys_ok & (div12 == `TCM_DIV12_LAST);
    wire logic tick4 = sys_ok & (div48[1:0] == `TCM_DIV4_LAST);
    wire logic tick48 = sys_ok & (div48 == `TCM_DIV48_LAST);
    wire logic tick_ext = pin_rise[2] & (ext8 == `TCM_EXT8_LAST);
    wire tcm_scale_t scale = tcm_scale_t'(clk_sel[`TCM_CK_SCALE_LSB+:2]);
    wire logic tick_scaled = (scale == TCM_SC_DIV12) ? tick12 : // [R12]
                             (scale == TCM_SC_DIV4) ? tick4 :
                             (scale == TCM_SC_DIV48) ? tick48 :
                             tick_ext; // [R5]

    ////////////////////////////////////////////////////////////////////////
    // timers 0 and 1
    logic [1:0] t01_tick;
    logic [1:0] t01_base;
    logic [17:0] t01_nx [2];
    tcm_mode_t t01_mode [2];

    generate
        for (genvar i = 0; i < 2; i++) begin : g_t01
            wire logic run = t01_ctl[`TCM_T01_RUN_LSB+i];
            wire logic cntr = t01_ctl[`TCM_T01_CNTR_LSB+i];
            assign t01_mode[i] = tcm_mode_t'(t01_ctl[2*i+:2]);
            assign t01_base[i] = clk_sel[`TCM_CK_T0SYS+i] ? // [R13]
                                 sys_ok : tick_scaled; // [R4]
            assign t01_tick[i] = run & sys_ok & // [R7]
                                 (cntr ? pin_fall[i] : t01_base[i]);
            // timer 1 halts in split mode; its run bit drives the high byte
            assign t01_nx[i] = tcm_t01_step(t01_mode[i], t01_cnt[i],
                (i == 1 && t01_mode[i] == TCM_MSPLIT) ? 1'b0 : t01_tick[i],
                (i == 0) & t01_ctl[`TCM_T01_RUN_LSB+1] & t01_base[0]
                & sys_ok);
            wire logic [31:0] cnt_wd = tcm_merge({16'h0000, t01_cnt[i]},
                WB_DAT_IN, WB_SEL_IN);
            always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
                if (!RSTN_IN) begin
                    t01_cnt[i] <= `TCM_RST_CNT;
                end else if (wr_t01cnt[i]) begin
                    t01_cnt[i] <= cnt_wd[15:0];
                end else begin
                    t01_cnt[i] <= t01_nx[i][15:0]; // [R1]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // timers 2 and 3
    logic [1:0] t23_tlo;
    logic [1:0] t23_thi;
    logic [17:0] t23_nx [2];

    generate
        for (genvar i = 0; i < 2; i++) begin : g_t23
            localparam int B = `TCM_T23_STRIDE * i;
            wire logic run = t23_ctl[B+`TCM_T23_RUN];
            wire logic split = t23_ctl[B+`TCM_T23_SPLIT];
            wire logic base = t23_ctl[B+`TCM_T23_XCLK] ? // [R6]
                              tick_ext : tick12;
            // only the external clock keeps timer 3 going in suspend
            wire logic base_ok = base & ((i == 1) | sys_ok); // [R10]
            assign t23_tlo[i] = run & (clk_sel[`TCM_CK_T2LSYS+2*i] ?
                                sys_ok : base_ok); // [R14]
            assign t23_thi[i] = run & split & // [R14]
                (clk_sel[`TCM_CK_T2HSYS+2*i] ? sys_ok : base_ok);
            assign t23_nx[i] = tcm_ar_step(split, t23_cnt[i], t23_rld[i],
                                           t23_tlo[i], t23_thi[i]);
            wire logic [31:0] cnt_wd = tcm_merge({16'h0000, t23_cnt[i]},
                WB_DAT_IN, WB_SEL_IN);
            wire logic [31:0] rld_wd = tcm_merge({16'h0000, t23_rld[i]},
                WB_DAT_IN, WB_SEL_IN);
            always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
                if (!RSTN_IN) begin
                    t23_cnt[i] <= `TCM_RST_CNT;
                    t23_rld[i] <= `TCM_RST_CNT;
                end else begin
                    if (wr_t23cnt[i]) begin
                        t23_cnt[i] <= cnt_wd[15:0];
                    end else begin
                        t23_cnt[i] <= t23_nx[i][15:0]; // [R1]
                    end
                    if (wr_t23rld[i]) begin
                        t23_rld[i] <= rld_wd[15:0];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // flags: write one clears, a set in the same cycle wins
    wire logic [6:0] ovf_set = {t23_nx[1][17:16], t23_nx[0][17:16],
                                t01_nx[0][17], t01_nx[1][16], t01_nx[0][16]};
    wire logic [6:0] ovf_clr = wr_fl & WB_SEL_IN[0] ? WB_DAT_IN[6:0] : 7'h00;
    wire logic [6:0] next_ovf = (ovf & ~ovf_clr) | ovf_set;
    wire logic [31:0] rd_data =
        (adr == `TCM_OFS_CKSEL) ? {24'h000000, clk_sel} :
        (adr == `TCM_OFS_T01CTL) ? {24'h000000, t01_ctl} :
        (adr == `TCM_OFS_T0CNT) ? {16'h0000, t01_cnt[0]} :
        (adr == `TCM_OFS_T1CNT) ? {16'h0000, t01_cnt[1]} :
        (adr == `TCM_OFS_T23CTL) ? {26'h0000000, t23_ctl} :
        (adr == `TCM_OFS_T2CNT) ? {16'h0000, t23_cnt[0]} :
        (adr == `TCM_OFS_T2RLD) ? {16'h0000, t23_rld[0]} :
        (adr == `TCM_OFS_T3CNT) ? {16'h0000, t23_cnt[1]} :
        (adr == `TCM_OFS_T3RLD) ? {16'h0000, t23_rld[1]} :
        (adr == `TCM_OFS_FLAGS) ? {25'h0000000, ovf} : 32'h00000000;

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ack <= 1'b0;
            WB_DAT_OUT <= 32'h00000000;
            clk_sel <= `TCM_RST_CKSEL;
            t01_ctl <= `TCM_RST_T01CTL;
            t23_ctl <= `TCM_RST_T23CTL;
            ovf <= `TCM_RST_FLAGS;
            WAKE_OUT <= 1'b0;
        end else begin
            ack <= req;
            WB_DAT_OUT <= req ? rd_data : 32'h00000000;
            if (wr_ck && WB_SEL_IN[0]) begin
                clk_sel <= WB_DAT_IN[7:0];
            end
            if (wr_t01 && WB_SEL_IN[0]) begin
                t01_ctl <= WB_DAT_IN[7:0];
            end
            if (wr_t23 && WB_SEL_IN[0]) begin
                t23_ctl <= WB_DAT_IN[5:0];
            end
            ovf <= next_ovf;
            WAKE_OUT <= susp & (next_ovf[`TCM_FL_T3L] | // [R11]
                                next_ovf[`TCM_FL_T3H]);
        end
    end
    assign WB_ACK_OUT = ack;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence s_t0_wrap16;
        t01_mode[0] == TCM_M16 && t01_tick[0] && t01_cnt[0] == 16'hFFFF
        && !wr_t01cnt[0];
    endsequence
    property p_t0_wrap16;
        s_t0_wrap16 |=> t01_cnt[0] == 16'h0000 && ovf[`TCM_FL_T0];
    endproperty
    a_t0_wrap16: assert property (p_t0_wrap16) // [R2]
        else $error("timer 0 16-bit wrap wrong");

    property p_t0_wrap13;
        t01_mode[0] == TCM_M13 && t01_tick[0] && !wr_t01cnt[0]
        && {t01_cnt[0][15:8], t01_cnt[0][4:0]} == 13'h1FFF
        |=> {t01_cnt[0][15:8], t01_cnt[0][4:0]} == 13'h0000
        && ovf[`TCM_FL_T0];
    endproperty
    a_t0_wrap13: assert property (p_t0_wrap13) // [R15]
        else $error("13-bit rollover wrong");

    property p_t0_reload8;
        t01_mode[0] == TCM_M8AR && t01_tick[0] && !wr_t01cnt[0]
        && t01_cnt[0][7:0] == 8'hFF
        |=> t01_cnt[0][7:0] == $past(t01_cnt[0][15:8]);
    endproperty
    a_t0_reload8: assert property (p_t0_reload8) // [R2]
        else $error("8-bit reload wrong");

    property p_t2_reload16;
        !t23_ctl[`TCM_T23_SPLIT] && t23_tlo[0] && !wr_t23cnt[0]
        && t23_cnt[0] == 16'hFFFF
        |=> t23_cnt[0] == $past(t23_rld[0]) && ovf[`TCM_FL_T2L];
    endproperty
    a_t2_reload16: assert property (p_t2_reload16) // [R3]
        else $error("timer 2 16-bit reload wrong");

    property p_t0_event;
        t01_ctl[`TCM_T01_CNTR_LSB] && t01_ctl[`TCM_T01_RUN_LSB] && sys_ok
        && t01_mode[0] == TCM_M16 && !wr_t01cnt[0]
        |-> t01_tick[0] == pin_fall[0];
    endproperty
    a_t0_event: assert property (p_t0_event) // [R7]
        else $error("event count not from pin edge");

    property p_div4_gap;
        scale == TCM_SC_DIV4 && tick_scaled
        |=> (!tick_scaled || scale != TCM_SC_DIV4) [*3];
    endproperty
    a_div4_gap: assert property (p_div4_gap) // [R12]
        else $error("divide by 4 spacing wrong");

    property p_t0_sysclk;
        clk_sel[`TCM_CK_T0SYS] && !t01_ctl[`TCM_T01_CNTR_LSB]
        && t01_ctl[`TCM_T01_RUN_LSB] && sys_ok |-> t01_tick[0];
    endproperty
    a_t0_sysclk: assert property (p_t0_sysclk) // [R13]
        else $error("timer 0 not on system clock");

    property p_t3_suspend;
        susp && tick_ext && t23_ctl[3+`TCM_T23_RUN]
        && t23_ctl[3+`TCM_T23_XCLK] && !clk_sel[`TCM_CK_T2LSYS+2]
        |-> t23_tlo[1] && !t23_tlo[0] && !t01_tick[0];
    endproperty
    a_t3_suspend: assert property (p_t3_suspend) // [R10]
        else $error("timer 3 stalled in suspend");

    property p_wake;
        susp && ovf_set[`TCM_FL_T3L] |=> WAKE_OUT ##1 (WAKE_OUT || !susp);
    endproperty
    a_wake: assert property (p_wake) // [R11]
        else $error("no wake on timer 3 overflow");

    property p_flag_set_wins;
        ovf_set[`TCM_FL_T0] && ovf_clr[`TCM_FL_T0] |=> ovf[`TCM_FL_T0];
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins) // [R15]
        else $error("flag set lost to clear");

endmodule // tcm_timers

/* rtl/tcm_cfg.svh */
// Purpose: constants of the timer clock and mode block
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes: offsets, field positions, reset values and divider counts
//
// Operation
// [R1] four timers, each sixteen bits wide
// [R2] timers 0/1: 13-bit, 16-bit, 8-bit reload; 0 splits
// [R3] timers 2/3: 16-bit reload or two 8-bit reload
// [R4] timer 0/1 clock from five sources
// [R5] shared prescaled clock, per-timer choice versus system clock
// [R6] timers 2/3: sysclk, sysclk/12, external/8
// [R7] counter mode counts falling edges on event pin
// [R8] events no faster than quarter system clock
// [R9] event levels held two system clocks minimum
// [R10] timer 3 counts external clock in suspend
// [R11] timer 3 overflow wakes device from suspend
// [R12] prescale codes: /12, /4, /48, external/8
// [R13] sysclk select 1 uses sysclk; ignored counting
// [R14] timers 2/3 byte selects: sysclk or own choice
// [R15] 13-bit rollover from 1FFF sets overflow flag
// [R16] event pins synchronised, falling edge gives one count
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH

`define TCM_OFS_CKSEL 8'h00
`define TCM_OFS_T01CTL 8'h04
`define TCM_OFS_T0CNT 8'h08
`define TCM_OFS_T1CNT 8'h0C
`define TCM_OFS_T23CTL 8'h10
`define TCM_OFS_T2CNT 8'h14
`define TCM_OFS_T2RLD 8'h18
`define TCM_OFS_T3CNT 8'h1C
`define TCM_OFS_T3RLD 8'h20
`define TCM_OFS_FLAGS 8'h24

// timer_clock_select fields
`define TCM_CK_SCALE_LSB 0
`define TCM_CK_T0SYS 2
`define TCM_CK_T2LSYS 4
`define TCM_CK_T2HSYS 5
// timer 0/1 control: mode pair per timer, then counter and run bits
`define TCM_T01_MODE_LSB 0
`define TCM_T01_CNTR_LSB 4
`define TCM_T01_RUN_LSB 6
// timer 2/3 control: three bits per timer
`define TCM_T23_STRIDE 3
`define TCM_T23_SPLIT 0
`define TCM_T23_RUN 1
`define TCM_T23_XCLK 2
// overflow flags
`define TCM_FL_T0 0
`define TCM_FL_T0H 2
`define TCM_FL_T2L 3
`define TCM_FL_T3L 5
`define TCM_FL_T3H 6

`define TCM_RST_CKSEL 8'h00
`define TCM_RST_T01CTL 8'h00
`define TCM_RST_T23CTL 6'h00
`define TCM_RST_CNT 16'h0000
`define TCM_RST_FLAGS 7'h00

// dividers: terminal counts
`define TCM_DIV12_LAST 4'hB
`define TCM_DIV48_LAST 6'h2F
`define TCM_DIV4_LAST 2'h3
`define TCM_EXT8_LAST 3'h7

`endif

/* rtl/tcm_pkg.sv */
// Purpose: types of the timer clock and mode block
// Assumes: constants come from tcm_cfg.svh
// Notes: encodings match the control fields bit for bit
package tcm_pkg;

    typedef enum logic [1:0] {
        TCM_M13 = 2'b00,
        TCM_M16 = 2'b01,
        TCM_M8AR = 2'b10,
        TCM_MSPLIT = 2'b11
    } tcm_mode_t;

    typedef enum logic [1:0] {
        TCM_SC_DIV12 = 2'b00,
        TCM_SC_DIV4 = 2'b01,
        TCM_SC_DIV48 = 2'b10,
        TCM_SC_EXT8 = 2'b11
    } tcm_scale_t;

endpackage

/* rtl/tcm_edge_sync.sv */
// Purpose: pin synchroniser with edge pulses
// Assumes: pin is asynchronous to clk_in
// Notes: pulses are one clk_in cycle, one to two cycles after the pin
module tcm_edge_sync (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic pin_in,
    output logic fall_out,
    output logic rise_out
);

    logic meta;
    logic sync;
    logic prev;

    // levels shorter than two clocks may be missed
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin_in; // [R9]
            sync <= meta;
            prev <= sync;
        end
    end

    assign fall_out = prev & ~sync; // [R16]
    assign rise_out = sync & ~prev;

endmodule // tcm_edge_sync

/* sim/tcm_ext_src.sv */
// Purpose: far-side model: event pins and external oscillator
// Assumes: event pins have pull-ups, so they idle high
// Notes: the oscillator runs free, unrelated in phase to the system clock
module tcm_ext_src #(
    parameter int OSC_HALF_NS = 23
) (
    input wire logic clk_in,
    output logic ev0_out,
    output logic ev1_out,
    output logic osc_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ev0_out = 1'b1;
        ev1_out = 1'b1;
        osc_out = 1'b0;
    end

    // a real oscillator keeps running whatever the device does
    always #(OSC_HALF_NS) osc_out = ~osc_out;

    ////////////////////////////////////////////////////////////////////
    // low level lasts three clocks, high level four, one event per seven clocks
    task automatic send_falls(input logic which, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            if (which) ev1_out <= 1'b0;
            else ev0_out <= 1'b0;
            repeat (3) @(posedge clk_in);
            if (which) ev1_out <= 1'b1;
            else ev0_out <= 1'b1;
            repeat (3) @(posedge clk_in);
        end
    endtask
endmodule // tcm_ext_src

/* sim/timer_clock_and_mode_set_tb.sv */
// Purpose: self-checking bench of the timer clock and mode block
// Assumes: one-cycle ack, byte offsets from tcm_cfg.svh
// Notes: tick rates are checked within a small tolerance for phase
`include "tcm_cfg.svh"
module timer_clock_and_mode_set_tb import tcm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int W = 480;
    localparam int NR = 11;
    localparam int OSC_HALF = 23;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic ack;
    logic ev0, ev1, osc, wake;
    logic suspend = 1'b0;
    logic [31:0] rd;
    logic [31:0] v;
    int n_errors = 0;
    int cmp_count = 0;
    int n0, n1, t;
    // rate table: clock select, timer 2/3 control, count offset, divisor
    logic [7:0] r_ck [NR] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h03, 8'h08,
        8'h10, 8'h00, 8'h00, 8'h40, 8'h00};
    logic [7:0] r_23 [NR] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h02, 8'h02, 8'h06, 8'h10, 8'h30};
    logic [7:0] r_ofs [NR] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h0C,
        8'h14, 8'h14, 8'h14, 8'h1C, 8'h1C};
    int r_div [NR] = '{12, 4, 48, 1, 0, 1, 1, 12, 0, 1, 0};

    always #5 clk = ~clk;

    tcm_timers u_tcm_timers (.CLK_IN(clk), .RSTN_IN(rstn),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
        .WB_SEL_IN(sel), .WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r),
        .WB_ACK_OUT(ack), .TIM0_EVENT_PIN_IN(ev0),
        .TIM1_EVENT_PIN_IN(ev1), .EXT_OSC_IN(osc),
        .SUSPEND_IN(suspend), .WAKE_OUT(wake));

    tcm_ext_src #(.OSC_HALF_NS(OSC_HALF)) u_tcm_ext_src (.clk_in(clk),
        .ev0_out(ev0), .ev1_out(ev1), .osc_out(osc));

    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // prescaler phase and pin sync make the edges fuzzy by a tick or two
    task automatic chk_near(input logic [31:0] got, input int exp);
        cmp_count++;
        if ((^got) === 1'bx || int'(got) > exp + 2 || int'(got) < exp - 2)
        begin
            n_errors++;
            $display("Error t=%0t count %h expected about %0d", $time,
                got, exp);
        end
    endtask

    // classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat_w <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = dat_r;
        if (k >= 20) begin
            n_errors++;
            $display("Error t=%0t no bus answer", $time);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk_eq(rd, exp);
    endtask

    function automatic int exp_ticks(input int div);
        if (div == 0) return (W + 3) * 10 / (16 * OSC_HALF);
        return (W + 3) / div;
    endfunction

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        $display("Error t=%0t watchdog ran out", $time);
        print_verdict();
    end

    initial begin
        void'($urandom(43));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int a = 0; a <= 9; a++) rdchk(8'(a * 4), 32'h0);
        rdchk(8'h3C, 32'h0);
        chk_eq({31'h0, wake}, 32'h0);
        repeat (4) begin
            v = $urandom;
            wb(1'b1, `TCM_OFS_CKSEL, v);
            rdchk(`TCM_OFS_CKSEL, {24'h0, v[7:0]});
            wb(1'b1, 8'h3C, v);
            rdchk(8'h3C, 32'h0);
        end
        // tick rates of every clock source
        wb(1'b1, `TCM_OFS_T01CTL, 32'hC5);
        for (int i = 0; i < NR; i++) begin
            wb(1'b1, `TCM_OFS_CKSEL, {24'h0, r_ck[i]});
            wb(1'b1, `TCM_OFS_T23CTL, {24'h0, r_23[i]});
            wb(1'b1, r_ofs[i], 32'h0);
            repeat (W) @(posedge clk);
            wb(1'b0, r_ofs[i], 32'h0);
            chk_near(rd,
                exp_ticks(r_div[i]));
        end
        // timer 2 split: high byte on system clock, low byte on /12
        wb(1'b1, `TCM_OFS_CKSEL, 32'h20);
        wb(1'b1, `TCM_OFS_T23CTL, 32'h03);
        wb(1'b1, `TCM_OFS_T2CNT, 32'h0);
        repeat (W) @(posedge clk);
        wb(1'b0, `TCM_OFS_T2CNT, 32'h0);
        chk_near({24'h0, rd[15:8]}, (W + 3) % 256);
        chk_near({24'h0, rd[7:0]}, exp_ticks(12));
        wb(1'b1, `TCM_OFS_T23CTL, 32'h0);
        // a clear that lands on the overflow edge loses to the set
        wb(1'b1, `TCM_OFS_CKSEL, 32'h04);
        wb(1'b1, `TCM_OFS_T01CTL, 32'h41);
        wb(1'b1, `TCM_OFS_T0CNT, 32'hFFFD);
        wb(1'b1, `TCM_OFS_FLAGS, 32'h01);
        wb(1'b0, `TCM_OFS_FLAGS, 32'h0);
        chk_eq(rd & 32'h1, 32'h1);
        // event counting, clock selects set but ignored
        wb(1'b1, `TCM_OFS_CKSEL, 32'h0C);
        wb(1'b1, `TCM_OFS_T01CTL, 32'hF5);
        wb(1'b1, `TCM_OFS_T0CNT, 32'h0);
        wb(1'b1, `TCM_OFS_T1CNT, 32'h0);
        n0 = 1 + $urandom % 5;
        n1 = 1 + $urandom % 5;
        u_tcm_ext_src.send_falls(1'b0, n0);
        u_tcm_ext_src.send_falls(1'b1, n1);
        repeat (5) @(posedge clk);
        rdchk(`TCM_OFS_T0CNT, 32'(n0));
        rdchk(`TCM_OFS_T1CNT, 32'(n1));
        // 13-bit rollover on a single event
        wb(1'b1, `TCM_OFS_T01CTL, 32'h50);
        wb(1'b1, `TCM_OFS_T0CNT, 32'hFF1F);
        wb(1'b1, `TCM_OFS_FLAGS, 32'h7F);
        u_tcm_ext_src.send_falls(1'b0, 1);
        repeat (5) @(posedge clk);
        rdchk(`TCM_OFS_T0CNT, 32'h0);
        rdchk(`TCM_OFS_FLAGS, 32'h1);
        wb(1'b1, `TCM_OFS_FLAGS, 32'h1);
        rdchk(`TCM_OFS_FLAGS, 32'h0);
        // 8-bit reload: low byte takes the high byte on overflow
        wb(1'b1, `TCM_OFS_T01CTL, 32'h52);
        wb(1'b1, `TCM_OFS_T0CNT, 32'h80FF);
        u_tcm_ext_src.send_falls(1'b0, 1);
        repeat (5) @(posedge clk);
        rdchk(`TCM_OFS_T0CNT, 32'h8080);
        // timer 3 on the oscillator wakes the device from suspend
        wb(1'b1, `TCM_OFS_T01CTL, 32'h0);
        wb(1'b1, `TCM_OFS_CKSEL, 32'h0);
        wb(1'b1, `TCM_OFS_T3RLD, 32'h0);
        wb(1'b1, `TCM_OFS_T3CNT, 32'hFFF0);
        wb(1'b1, `TCM_OFS_FLAGS, 32'h7F);
        wb(1'b1, `TCM_OFS_T23CTL, 32'h30);
        suspend <= 1'b1;
        t = 0;
        while (wake !== 1'b1 && t < 1500) begin
            @(posedge clk);
            t++;
        end
        chk_eq({31'h0, wake}, 32'h1);
        wb(1'b0, `TCM_OFS_FLAGS, 32'h0);
        chk_eq(rd, 32'h20);
        suspend <= 1'b0;
        wb(1'b1, `TCM_OFS_FLAGS, 32'h7F);
        wb(1'b1, `TCM_OFS_T23CTL, 32'h0);
        @(posedge clk);
        chk_eq({31'h0, wake}, 32'h0);
        print_verdict();
    end
endmodule // timer_clock_and_mode_set_tb
